// file: data_space_access_props.sv
// Purpose: Concurrent checks on the ports of the data-space access unit.
// Assumes: Peripheral read data answers in the cycle of the request.
// Notes: Attached by bind from the testbench top file.
`timescale 1ns/10ps
module data_space_access_props
    import data_space_pkg::*;
(
    input wire logic core_clk, // Core clock.
    input wire logic rst_b, // Reset, active low.
    input wire req_t req, // Request from the pipeline.
    input wire rsp_t rsp, // Registered answer.
    input wire sfr_bus_t sfr_bus, // Peripheral access.
    input wire logic [15:0] sfr_rd_data, // Peripheral read data.
    input wire logic [15:0] stack_pointer, // Stack pointer.
    input wire logic [15:0] stack_limit, // Stack limit.
    input wire logic addr_err_trap, // Address error flag.
    input wire logic addr_err_ack, // Address error acknowledge.
    input wire logic stack_err_trap, // Stack error flag.
    input wire logic stack_err_ack // Stack error acknowledge.
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////
    // Short names for the request kinds; pops into the pointer itself are left out.
    wire ld = req.valid && req.op == OP_LOAD && req.mode == AM_DIRECT;
    wire st = req.valid && req.op == OP_STORE && req.mode == AM_DIRECT;
    wire psh = req.valid && (req.op == OP_PUSH || req.op == OP_CALL_PUSH_HI || req.op == OP_EXC_PUSH_HI);
    wire pop = req.valid && req.op == OP_POP && req.dst_reg != 4'hF;
    wire [15:0] da = req.direct_addr;
    wire [15:0] near = {3'h0, da[12:0]};
    wire [7:0] pick = da[0] ? sfr_rd_data[15:8] : sfr_rd_data[7:0];
    // The limit word lies in block 1 but is no peripheral, so it is excluded.
    wire imp = da < 16'h0100 && da[15:1] != 15'h0010;
    ////////////////////////////////////////////////////////////////////////
    // Address forming, lanes and region decode.
    a_near_field: assert property (ld && !req.move_instruction |=> rsp.effective_address == $past(near))
        else $error("near direct address not cut to 13 bits");
    a_move_field: assert property (ld && req.move_instruction |=> rsp.effective_address == $past(da))
        else $error("move direct address not full width");
    a_word_odd: assert property ((ld || st) && !req.is_byte && da[0] |=> addr_err_trap)
        else $error("odd word access without address trap");
    a_odd_store_quiet: assert property (st && !req.is_byte && da[0] |-> sfr_bus.lane_we == 2'h0)
        else $error("odd word store reached a lane");
    a_byte_lane: assert property (st && req.is_byte && imp |-> sfr_bus.lane_we == {da[0], !da[0]})
        else $error("byte store strobed the wrong lane");
    a_byte_read: assert property (ld && req.is_byte && imp |=> rsp.rd_data == {8'h00, $past(pick)})
        else $error("byte read not steered to low lane");
    a_unimpl_zero: assert property (ld && req.move_instruction && da >= 16'h0100 && da <= 16'h07FF
        |-> !sfr_bus.rd_en ##1 rsp.rd_data == 16'h0000)
        else $error("unimplemented register space not read as zero");
    ////////////////////////////////////////////////////////////////////////
    // Stack pointer steps and stack checks.
    a_push_step: assert property (psh |=> stack_pointer == $past(stack_pointer) + 16'h0002)
        else $error("push did not advance pointer by two");
    a_pop_step: assert property (pop |=> stack_pointer == $past(stack_pointer) - 16'h0002)
        else $error("pop did not step pointer back by two");
    a_limit_push: assert property (psh && stack_pointer > stack_limit |=> stack_err_trap)
        else $error("push above limit without stack trap");
    a_underflow: assert property (pop && stack_pointer < 16'h0802 |=> stack_err_trap)
        else $error("stack underflow without stack trap");
    a_addr_held: assert property (addr_err_trap && !addr_err_ack |=> addr_err_trap)
        else $error("address trap dropped without acknowledge");
    a_stack_held: assert property (stack_err_trap && !stack_err_ack |=> stack_err_trap)
        else $error("stack trap dropped without acknowledge");
endmodule // data_space_access_props

// file: data_space_access_stack_check.sv
// Purpose: Data-space access unit with byte lanes, alignment check, region decode and stack checks.
// Assumes: One request per cycle from the execution pipeline, all inputs on core_clk.
// Notes: Answers and trap flags are registered; peripheral read data returns in the same cycle.
`timescale 1ns/10ps

module data_space_access_stack_check
    import data_space_pkg::*;
(
    input wire logic core_clk, // Core clock, 200 MHz.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire req_t req, // Request from the execution pipeline.
    output rsp_t rsp, // Registered answer.
    output sfr_bus_t sfr_bus, // Access to peripheral register blocks.
    input wire logic [15:0] sfr_rd_data, // Peripheral read data, same cycle.
    output logic [15:0] stack_pointer, // Current stack pointer register.
    output logic [15:0] stack_limit, // Current stack limit register.
    output logic addr_err_trap, // Address error trap request, held.
    input wire logic addr_err_ack, // Exception logic takes the address error.
    output logic stack_err_trap, // Stack error trap request, held.
    input wire logic stack_err_ack // Exception logic takes the stack error.
);

    ////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Step size for a pointer update, used by post-increment only; the stack steps by WORD_STEP.
    function automatic logic [15:0] step_of(input logic is_byte);
        step_of = is_byte ? BYTE_STEP : WORD_STEP;
    endfunction

    // Block index of an address in the register space.
    function automatic logic [5:0] region_of(input logic [15:0] addr);
        region_of = addr[SFR_REGION_SHIFT +: 6];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Storage.
    logic [15:0] wreg_reg [NUM_WREGS];
    logic [15:0] wreg_next [NUM_WREGS];
    logic [7:0] ram_lo [RAM_WORDS];
    logic [7:0] ram_hi [RAM_WORDS];
    logic [15:0] stack_limit_reg;
    logic addr_err_reg;
    logic stack_err_reg;
    rsp_t rsp_reg;

    ////////////////////////////////////////////////////////////////////////
    // Operation decode.
    wire logic is_load = req.valid && (req.op == OP_LOAD);
    wire logic is_store = req.valid && (req.op == OP_STORE);
    wire logic is_push = req.valid && (req.op == OP_PUSH || req.op == OP_CALL_PUSH_HI
                                       || req.op == OP_EXC_PUSH_HI);
    wire logic is_pop = req.valid && (req.op == OP_POP);
    wire logic is_sext = req.valid && (req.op == OP_SIGN_EXT);
    wire logic is_zext = req.valid && (req.op == OP_ZERO_EXT);
    wire logic is_stack_op = is_push || is_pop;
    wire logic is_mem = is_load || is_store || is_stack_op;
    wire logic is_rd = is_load || is_pop;
    wire logic is_wr = is_store || is_push;
    // Stack operations always move whole words.
    wire logic byte_access = req.is_byte && !is_stack_op;

    ////////////////////////////////////////////////////////////////////////
    // Effective address formation.
    wire logic [15:0] sp_now = wreg_reg[STACK_PTR_INDEX];
    wire logic [15:0] ptr_now = wreg_reg[req.src_reg];
    // Ordinary direct forms carry a 13-bit field, moves carry 16 bits.
    wire logic [15:0] direct_ea = req.move_instruction ? req.direct_addr
                                  : {3'b000, req.direct_addr[NEAR_FIELD_BITS-1:0]};
    wire logic [15:0] sp_pre_dec = sp_now - WORD_STEP;
    wire logic [15:0] mem_ea = is_push ? sp_now
                              : is_pop ? sp_pre_dec
                              : (req.mode == AM_DIRECT) ? direct_ea : ptr_now;
    wire logic ptr_is_sp = (req.mode != AM_DIRECT) && (req.src_reg == STACK_PTR_INDEX);
    wire logic uses_sp = is_stack_op || ((is_load || is_store) && ptr_is_sp);
    wire logic post_inc = (is_load || is_store) && (req.mode == AM_POST_INC);

    ////////////////////////////////////////////////////////////////////////
    // Error detection.
    // A word at an odd address is flagged; the read still completes.
    wire logic misaligned = is_mem && !byte_access && mem_ea[0];
    // Push at the limit is fine, so only an address beyond the limit traps.
    wire logic over_limit = uses_sp && (mem_ea > stack_limit_reg);
    wire logic under_floor = uses_sp && (mem_ea < STACK_FLOOR_ADDR);
    wire logic stack_fault = over_limit || under_floor;

    ////////////////////////////////////////////////////////////////////////
    // Region decode on the shared word address.
    wire logic [15:0] word_addr = {mem_ea[15:1], 1'b0};
    wire logic in_sfr = (mem_ea <= SFR_LAST_ADDR);
    wire logic hit_limit = (word_addr == STACK_LIMIT_ADDR);
    wire logic region_impl = SFR_REGION_MAP[region_of(mem_ea)];
    wire logic hit_periph = in_sfr && !hit_limit && region_impl;
    wire logic [15:0] ram_off = mem_ea - RAM_BASE_ADDR;
    wire logic in_ram = !in_sfr && (ram_off[15:1] < 15'(RAM_WORDS));
    wire logic [RAM_AW-1:0] ram_idx = ram_off[RAM_AW:1];

    ////////////////////////////////////////////////////////////////////////
    // Write data and lane strobes.
    // Call push clears the byte above the program counter; exception push fills it with status.
    wire logic [15:0] push_word = (req.op == OP_CALL_PUSH_HI) ? {8'h00, req.pc_msb}
                                 : (req.op == OP_EXC_PUSH_HI) ? {req.status_low_byte, req.pc_msb}
                                 : wreg_reg[req.dst_reg];
    wire logic [15:0] src_word = wreg_reg[req.dst_reg];
    // A byte store places the register low byte on both lanes; the strobe picks one.
    wire logic [15:0] wr_word = is_push ? push_word
                               : byte_access ? {src_word[7:0], src_word[7:0]} : src_word;
    // Writes of a misaligned word are dropped while the instruction still retires.
    wire logic wr_go = is_wr && !misaligned;
    wire logic [1:0] lane_we = !wr_go ? 2'b00
                              : byte_access ? {mem_ea[0], !mem_ea[0]} : 2'b11;

    ////////////////////////////////////////////////////////////////////////
    // Read path: whole word fetched, byte chosen by the lowest address bit.
    wire logic [15:0] ram_word = {ram_hi[ram_idx], ram_lo[ram_idx]};
    wire logic [15:0] limit_word = {stack_limit_reg[15:1], 1'b0};
    wire logic [15:0] fetch_word = !in_sfr ? (in_ram ? ram_word : 16'h0000)
                                  : hit_limit ? limit_word
                                  : hit_periph ? sfr_rd_data : 16'h0000;
    wire logic [15:0] rd_value = byte_access ? {8'h00, (mem_ea[0] ? fetch_word[15:8]
                                                : fetch_word[7:0])} : fetch_word;

    // Peripheral strobes come straight from the decode so the peripheral sees them this cycle.
    assign sfr_bus.rd_en = is_rd && hit_periph;
    assign sfr_bus.lane_we = hit_periph ? lane_we : 2'b00;
    assign sfr_bus.addr = word_addr;
    assign sfr_bus.wdata = wr_word;

    ////////////////////////////////////////////////////////////////////////
    // Working register next values. A pointer update and a data load may
    // target the same register; the load is applied last so it wins, which
    // matches the usual rule that the destination write retires after the
    // address update.
    always_comb begin
        for (int i = 0; i < NUM_WREGS; i++) begin
            wreg_next[i] = wreg_reg[i];
        end
        if (post_inc) begin
            wreg_next[req.src_reg] = ptr_now + step_of(byte_access);
        end
        if (is_push) begin
            wreg_next[STACK_PTR_INDEX] = sp_now + WORD_STEP;
        end
        if (is_pop) begin
            wreg_next[STACK_PTR_INDEX] = sp_pre_dec;
        end
        if (is_rd && byte_access) begin
            wreg_next[req.dst_reg] = {wreg_reg[req.dst_reg][15:8], rd_value[7:0]};
        end else if (is_rd) begin
            wreg_next[req.dst_reg] = rd_value;
        end
        if (is_sext) begin
            wreg_next[req.dst_reg] = {{8{wreg_reg[req.dst_reg][7]}}, wreg_reg[req.dst_reg][7:0]};
        end
        if (is_zext) begin
            wreg_next[req.dst_reg] = {8'h00, wreg_reg[req.dst_reg][7:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Working registers; the stack pointer starts at the bottom of RAM.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_WREGS; i++) begin
                wreg_reg[i] <= (i == int'(STACK_PTR_INDEX)) ? STACK_PTR_RESET : WREG_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_WREGS; i++) begin
                wreg_reg[i] <= wreg_next[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data RAM as two byte-wide lanes with separate strobes and no reset.
    always_ff @(posedge core_clk) begin
        if (in_ram && lane_we[0]) begin
            ram_lo[ram_idx] <= wr_word[7:0];
        end
        if (in_ram && lane_we[1]) begin
            ram_hi[ram_idx] <= wr_word[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stack limit holds its value through reset, so software must load it
    // before relying on the upper check. Bit zero is kept clear on every write.
    // A stack-pointer read right after this write still sees the new limit here,
    // but software keeps a gap to stay portable.
    always_ff @(posedge core_clk) begin
        if (in_sfr && hit_limit && lane_we[0]) begin
            stack_limit_reg[7:0] <= {wr_word[7:1], 1'b0};
        end
        if (in_sfr && hit_limit && lane_we[1]) begin
            stack_limit_reg[15:8] <= wr_word[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trap flags: a fault in the cycle of its acknowledge keeps the flag set.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_err_reg <= 1'b0;
            stack_err_reg <= 1'b0;
        end else begin
            addr_err_reg <= misaligned || (addr_err_reg && !addr_err_ack);
            stack_err_reg <= stack_fault || (stack_err_reg && !stack_err_ack);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered answer, one cycle after the request.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg.valid <= req.valid;
            rsp_reg.rd_data <= is_rd ? rd_value : 16'h0000;
            rsp_reg.effective_address <= is_mem ? mem_ea : 16'h0000;
        end
    end

    assign rsp = rsp_reg;
    assign stack_pointer = sp_now;
    assign stack_limit = limit_word;
    assign addr_err_trap = addr_err_reg;
    assign stack_err_trap = stack_err_reg;

endmodule // data_space_access_stack_check

// file: data_space_access_stack_check_tb.sv
// Purpose: Self-checking bench for the data-space access unit.
// Assumes: Peripheral model at 0000h to 00FFh, RAM from 0800h.
// Notes: Register contents are brought in by loads from model words set by the bench.
`timescale 1ns/10ps
module data_space_access_stack_check_tb;
    import data_space_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    req_t req = '0;
    logic addr_err_ack = 1'b0;
    logic stack_err_ack = 1'b0;
    rsp_t rsp;
    sfr_bus_t sfr_bus;
    logic [15:0] sfr_rd_data, stack_pointer, stack_limit;
    logic addr_err_trap, stack_err_trap;
    int miscompares = 0;
    int checks = 0;
    logic [31:0] seed = 32'hd011_558f;
    logic [15:0] a, b, v, lim;
    logic [7:0] pc_v = 8'h00;
    logic [7:0] sr_v = 8'h00;
    logic tr;
    logic [15:0] stk[$];
    always #2.5 core_clk = ~core_clk;
    data_space_access_stack_check i_data_space_access_stack_check (.core_clk(core_clk), .rst_b(rst_b),
        .req(req), .rsp(rsp), .sfr_bus(sfr_bus), .sfr_rd_data(sfr_rd_data), .stack_pointer(stack_pointer),
        .stack_limit(stack_limit), .addr_err_trap(addr_err_trap), .addr_err_ack(addr_err_ack),
        .stack_err_trap(stack_err_trap), .stack_err_ack(stack_err_ack));
    sfr_peripheral_model i_sfr_peripheral_model (.core_clk(core_clk), .sfr_bus(sfr_bus), .sfr_rd_data(sfr_rd_data));
    ////////////////////////////////////////////////////////////////////////
    // Xorshift source, so every run repeats the same values.
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Drives one request just after an edge; the answer is settled when it returns.
    task automatic issue(input op_t o, input mode_t m, input logic byt, input logic mv, input logic [3:0] s,
        input logic [3:0] d, input logic [15:0] ad);
        req = '{1'b1, o, m, byt, mv, s, d, ad, pc_v, sr_v};
        @(posedge core_clk);
        #1;
    endtask
    task automatic idle(input int n);
        req.valid = 1'b0;
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic setw(input logic [3:0] r, input logic [15:0] val);
        i_sfr_peripheral_model.mem[7'h30] = val;
        issue(OP_LOAD, AM_DIRECT, 1'b0, 1'b1, 4'h0, r, 16'h0060);
    endtask
    // The last request is withdrawn first, so the acknowledge edge cannot retake it and set a flag again.
    task automatic clr();
        req.valid = 1'b0;
        addr_err_ack = 1'b1;
        stack_err_ack = 1'b1;
        @(posedge core_clk);
        #1;
        addr_err_ack = 1'b0;
        stack_err_ack = 1'b0;
    endtask
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // The tests need about 150 cycles; 40000 leaves ample room.
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, lanes, alignment, decode, post-increment, stack.
    initial begin
        repeat (16) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        chk("reset sp", stack_pointer, 16'h0800);
        chk("reset traps", {14'h0000, addr_err_trap, stack_err_trap}, 16'h0000);
        a = rnd();
        b = rnd();
        i_sfr_peripheral_model.mem[7'h20] = a;
        i_sfr_peripheral_model.mem[7'h21] = b;
        i_sfr_peripheral_model.mem[7'h00] = b | 16'h0001;
        issue(OP_LOAD, AM_DIRECT, 1'b0, 1'b0, 4'h0, 4'h1, 16'hE040);
        chk("near ea", rsp.effective_address, 16'h0040);
        chk("near data", rsp.rd_data, a);
        issue(OP_LOAD, AM_DIRECT, 1'b1, 1'b0, 4'h0, 4'h2, 16'h0041);
        chk("byte read", rsp.rd_data, {8'h00, a[15:8]});
        issue(OP_LOAD, AM_DIRECT, 1'b0, 1'b0, 4'h0, 4'h3, 16'h0042);
        issue(OP_LOAD, AM_DIRECT, 1'b1, 1'b0, 4'h0, 4'h3, 16'h0041);
        issue(OP_STORE, AM_DIRECT, 1'b0, 1'b0, 4'h0, 4'h3, 16'h0046);
        chk("byte load", i_sfr_peripheral_model.mem[7'h23], {b[15:8], a[15:8]});
        issue(OP_STORE, AM_DIRECT, 1'b1, 1'b0, 4'h0, 4'h1, 16'h0047);
        chk("byte lane", i_sfr_peripheral_model.mem[7'h23], {a[7:0], a[15:8]});
        issue(OP_SIGN_EXT, AM_DIRECT, 1'b0, 1'b0, 4'h0, 4'h2, 16'h0000);
        issue(OP_ZERO_EXT, AM_DIRECT, 1'b0, 1'b0, 4'h0, 4'h3, 16'h0000);
        issue(OP_STORE, AM_DIRECT, 1'b0, 1'b0, 4'h0, 4'h2, 16'h0048);
        issue(OP_STORE, AM_DIRECT, 1'b0, 1'b0, 4'h0, 4'h3, 16'h004A);
        chk("sign ext", i_sfr_peripheral_model.mem[7'h24], {{8{a[15]}}, a[15:8]});
        chk("zero ext", i_sfr_peripheral_model.mem[7'h25], {8'h00, a[15:8]});
        $display("test lanes done");
        issue(OP_LOAD, AM_DIRECT, 1'b0, 1'b1, 4'h0, 4'h4, 16'h0041);
        chk("odd read done", {15'h0000, rsp.valid}, 16'h0001);
        idle(3);
        chk("addr trap", {15'h0000, addr_err_trap}, 16'h0001);
        clr();
        chk("addr ack", {15'h0000, addr_err_trap}, 16'h0000);
        issue(OP_STORE, AM_DIRECT, 1'b0, 1'b1, 4'h0, 4'h1, 16'h0043);
        chk("odd write", i_sfr_peripheral_model.mem[7'h21], b);
        chk("store trap", {15'h0000, addr_err_trap}, 16'h0001);
        clr();
        issue(OP_STORE, AM_DIRECT, 1'b0, 1'b1, 4'h0, 4'h1, 16'h2000);
        issue(OP_LOAD, AM_DIRECT, 1'b0, 1'b1, 4'h0, 4'h5, 16'h2000);
        chk("move ea", rsp.effective_address, 16'h2000);
        chk("move data", rsp.rd_data, a);
        issue(OP_LOAD, AM_DIRECT, 1'b0, 1'b1, 4'h0, 4'h5, 16'h0100);
        chk("unimpl", rsp.rd_data, 16'h0000);
        i_sfr_peripheral_model.mem[7'h70] = b;
        issue(OP_LOAD, AM_DIRECT, 1'b0, 1'b1, 4'h0, 4'h5, 16'h00E0);
        chk("last block", rsp.rd_data, b);
        setw(4'h6, 16'h0040);
        for (int i = 0; i < 4; i++) begin
            issue(OP_LOAD, AM_POST_INC, i < 2, 1'b0, 4'h6, 4'h7, 16'h0000);
            chk("post inc", rsp.effective_address, 16'(i < 2 ? 64 + i : 62 + 2 * i));
        end
        $display("test decode done");
        repeat (3) begin
            lim = 16'h0801 + (rnd() & 16'h000E);
            setw(4'h8, lim);
            issue(OP_STORE, AM_DIRECT, 1'b0, 1'b1, 4'h0, 4'h8, 16'h0020);
            chk("limit bit0", stack_limit, lim & 16'hFFFE);
            idle(1);
            tr = 1'b0;
            for (int i = 0; i < 9; i++) begin
                v = rnd();
                setw(4'h9, v);
                issue(OP_PUSH, AM_DIRECT, 1'b0, 1'b0, 4'h0, 4'h9, 16'h0000);
                stk.push_back(v);
                tr = tr | (16'(2048 + 2 * i) > (lim & 16'hFFFE));
                chk("push trap", {15'h0000, stack_err_trap}, {15'h0000, tr});
            end
            for (int i = 8; i >= 0; i--) begin
                issue(OP_POP, AM_DIRECT, 1'b0, 1'b0, 4'h0, 4'hA, 16'h0000);
                chk("pop data", rsp.rd_data, stk.pop_back());
                chk("pop sp", stack_pointer, 16'(2048 + 2 * i));
            end
            clr();
            issue(OP_POP, AM_DIRECT, 1'b0, 1'b0, 4'h0, 4'hA, 16'h0000);
            chk("underflow", {15'h0000, stack_err_trap}, 16'h0001);
            issue(OP_PUSH, AM_DIRECT, 1'b0, 1'b0, 4'h0, 4'h9, 16'h0000);
            clr();
        end
        pc_v = 8'(rnd());
        sr_v = 8'(rnd());
        issue(OP_CALL_PUSH_HI, AM_DIRECT, 1'b0, 1'b0, 4'h0, 4'h0, 16'h0000);
        issue(OP_EXC_PUSH_HI, AM_DIRECT, 1'b0, 1'b0, 4'h0, 4'h0, 16'h0000);
        issue(OP_POP, AM_DIRECT, 1'b0, 1'b0, 4'h0, 4'hB, 16'h0000);
        chk("exception push", rsp.rd_data, {sr_v, pc_v});
        issue(OP_POP, AM_DIRECT, 1'b0, 1'b0, 4'h0, 4'hB, 16'h0000);
        chk("call push", rsp.rd_data, {8'h00, pc_v});
        idle(2);
        $display("test stack done");
        finish_test();
    end
endmodule // data_space_access_stack_check_tb
bind data_space_access_stack_check data_space_access_props i_data_space_access_props (.core_clk, .rst_b, .req,
    .rsp, .sfr_bus, .sfr_rd_data, .stack_pointer, .stack_limit, .addr_err_trap, .addr_err_ack, .stack_err_trap,
    .stack_err_ack);

// file: data_space_pkg.sv
// Purpose: Shared constants and carrier types for the data-space access unit.
// Assumes: 16-bit data space, byte addressed, two byte lanes per word.
// Notes: Region map of the special function register space is one bit per 32-byte block.
package data_space_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Address map.
    localparam logic [15:0] SFR_LAST_ADDR = 16'h07FF;
    localparam logic [15:0] NEAR_LAST_ADDR = 16'h1FFF;
    localparam logic [15:0] STACK_FLOOR_ADDR = 16'h0800;
    localparam logic [15:0] RAM_BASE_ADDR = 16'h0800;
    localparam int RAM_WORDS = 4096;
    localparam int RAM_AW = 12;
    localparam logic [15:0] STACK_LIMIT_ADDR = 16'h0020;
    localparam int NEAR_FIELD_BITS = 13;
    localparam int SFR_REGION_SHIFT = 5;
    // One bit per 32-byte block from 0000h to 07FFh; a set bit marks an implemented block.
    localparam logic [63:0] SFR_REGION_MAP = 64'h0000_0000_0000_00FF;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and steps.
    localparam logic [15:0] STACK_PTR_RESET = 16'h0800;
    localparam logic [15:0] WREG_RESET = 16'h0000;
    localparam logic [15:0] BYTE_STEP = 16'h0001;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [3:0] STACK_PTR_INDEX = 4'hF;
    localparam int NUM_WREGS = 16;

    ////////////////////////////////////////////////////////////////////////
    // Operations and addressing modes.
    typedef enum logic [3:0] {
        OP_NONE, OP_LOAD, OP_STORE, OP_PUSH, OP_POP,
        OP_SIGN_EXT, OP_ZERO_EXT, OP_CALL_PUSH_HI, OP_EXC_PUSH_HI
    } op_t;

    typedef enum logic [1:0] {
        AM_INDIRECT, AM_POST_INC, AM_DIRECT
    } mode_t;

    typedef struct packed {
        logic valid;            // Request present this cycle.
        op_t op;                // Operation.
        mode_t mode;            // Addressing mode for loads and stores.
        logic is_byte;          // Byte operand when set, word when clear.
        logic move_instruction; // Move form: direct field is 16 bits wide.
        logic [3:0] src_reg;    // Pointer register for indirect modes.
        logic [3:0] dst_reg;    // Data register for load, store, push, pop, extend.
        logic [15:0] direct_addr; // Absolute address field.
        logic [7:0] pc_msb;     // Program counter most significant byte.
        logic [7:0] status_low_byte; // Status register low byte.
    } req_t;

    typedef struct packed {
        logic valid;            // Answer present.
        logic [15:0] rd_data;   // Read data, byte reads in the low lane.
        logic [15:0] effective_address; // Address that was used.
    } rsp_t;

    typedef struct packed {
        logic rd_en;            // Read of an implemented peripheral block.
        logic [1:0] lane_we;    // Write strobes, bit 1 high lane, bit 0 low lane.
        logic [15:0] addr;      // Word-aligned address.
        logic [15:0] wdata;     // Write data on both lanes.
    } sfr_bus_t;

endpackage

// file: sfr_peripheral_model.sv
// Purpose: Behavioural peripheral register blocks behind the access unit.
// Assumes: Implemented blocks cover 0000h to 00FFh, one entry per word.
// Notes: Unselected read data shows the inverse of the previous cycle's read data, so it toggles while idle.
`timescale 1ns/10ps
module sfr_peripheral_model
    import data_space_pkg::*;
(
    input wire logic core_clk, // Core clock.
    input wire sfr_bus_t sfr_bus, // Access from the unit.
    output logic [15:0] sfr_rd_data // Read data, same cycle.
);
    logic [15:0] mem [128];
    logic [15:0] last_reg = 16'h0000;
    initial foreach (mem[i]) mem[i] = 16'h0000;
    ////////////////////////////////////////////////////////////////////////
    // Each lane has its own strobe, so a byte write leaves the other lane alone.
    always @(posedge core_clk) begin
        if (sfr_bus.lane_we[0]) mem[sfr_bus.addr[7:1]][7:0] <= sfr_bus.wdata[7:0];
        if (sfr_bus.lane_we[1]) mem[sfr_bus.addr[7:1]][15:8] <= sfr_bus.wdata[15:8];
        last_reg <= sfr_rd_data;
    end
    // Inverting when idle keeps the unit from living off a leftover value.
    assign sfr_rd_data = sfr_bus.rd_en ? mem[sfr_bus.addr[7:1]] : ~last_reg;
endmodule // sfr_peripheral_model
